// *** ccd_cfg_if.sv ***
// Configuration fields passed from the register file to the two engines, and status passed back from them.
// Assumes all parties share mclk_in.
`default_nettype none

interface ccd_cfg_if;
  logic chop_enable;
  logic [3:0] chop_settle_delay;
  logic detect_mode_enable;
  logic [2:0] detect_exceed_count;
  logic [2:0] detect_window_length;
  logic chop_settling;
  logic window_running;

  modport regs(output chop_enable, chop_settle_delay, detect_mode_enable,
               detect_exceed_count, detect_window_length,
               input chop_settling, window_running);
  modport chop(input chop_enable, chop_settle_delay, output chop_settling);
  modport det(input detect_mode_enable, detect_exceed_count, detect_window_length,
              output window_running);
endinterface : ccd_cfg_if

`default_nettype wire

// *** ccd_chop_timer.sv ***
// Global-chop settling timer.
// Assumes mod_tick_in pulses once per modulator clock period and chop_start_in marks each chop phase.
`default_nettype none

module ccd_chop_timer (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  ccd_cfg_if.chop cfg,
  input wire logic mod_tick_in,
  input wire logic chop_start_in,
  output logic measure_ok_out
);
  ccd_pkg::ccd_chop_e state, next_state;
  logic [16:0] cnt, next_cnt;
  logic en_d, next_en_d;

  // [RQ1] Settle before measuring
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_en_d = cfg.chop_enable;
    case (state)
      ccd_pkg::CCD_CHOP_IDLE: begin
        if (cfg.chop_enable) begin
          next_state = ccd_pkg::CCD_CHOP_SETTLE;
          next_cnt = ccd_pkg::chop_delay(cfg.chop_settle_delay);
        end
      end
      ccd_pkg::CCD_CHOP_SETTLE: begin
        if (mod_tick_in && cnt == 17'h00001) begin
          next_state = ccd_pkg::CCD_CHOP_MEASURE;
          next_cnt = 17'h00000;
        end else if (mod_tick_in) begin
          next_cnt = cnt - 17'h00001;
        end
      end
      ccd_pkg::CCD_CHOP_MEASURE: begin
        if (chop_start_in) begin
          next_state = ccd_pkg::CCD_CHOP_SETTLE;
          next_cnt = ccd_pkg::chop_delay(cfg.chop_settle_delay);
        end
      end
      default: next_state = ccd_pkg::CCD_CHOP_IDLE;
    endcase
    // Disabling wins over any pending settle
    if (!cfg.chop_enable) begin
      next_state = ccd_pkg::CCD_CHOP_IDLE;
      next_cnt = 17'h00000;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ccd_pkg::CCD_CHOP_IDLE;
      cnt <= 17'h00000;
      en_d <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      en_d <= next_en_d;
    end
  end

  assign cfg.chop_settling = (state == ccd_pkg::CCD_CHOP_SETTLE);
  assign measure_ok_out = (state != ccd_pkg::CCD_CHOP_SETTLE);

  a_chop_delay_load: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ1]
    (cfg.chop_enable && !en_d) |=> (cnt == ccd_pkg::chop_delay($past(cfg.chop_settle_delay))))
    else $error("Chop delay not loaded from code");
  a_chop_off_measure: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ1]
    !cfg.chop_enable |=> measure_ok_out)
    else $error("Settling while chop disabled");
endmodule : ccd_chop_timer

`default_nettype wire

// *** ccd_conv_model.sv ***
// Converter front-end model: modulator ticks, chop phase marks and four-channel results.
// Assumes it shares mclk_in with the block; the bench drives it through its tasks.
`default_nettype none

module ccd_conv_model #(
  parameter int TICK_DIV = 3
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  output logic mod_tick_out,
  output logic chop_start_out,
  output logic conv_valid_out,
  output logic [95:0] conv_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int div;

  // Modulator clock runs free, so its tick never stops between conversions
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div <= 0;
      mod_tick_out <= 1'b0;
    end else begin
      div <= (div == TICK_DIV - 1) ? 0 : div + 1;
      mod_tick_out <= (div == TICK_DIV - 1);
    end
  end

  initial begin
    chop_start_out = 1'b0;
    conv_valid_out = 1'b0;
    conv_data_out = 96'h0;
  end

  // Stale data show the inverse, so a late sample cannot pass by luck
  task automatic send(input logic [95:0] d);
    @(posedge mclk_in);
    conv_valid_out <= 1'b1;
    conv_data_out <= d;
    @(posedge mclk_in);
    conv_valid_out <= 1'b0;
    conv_data_out <= ~d;
  endtask : send

  task automatic chop_mark();
    @(posedge mclk_in);
    chop_start_out <= 1'b1;
    @(posedge mclk_in);
    chop_start_out <= 1'b0;
  endtask : chop_mark
endmodule : ccd_conv_model

`default_nettype wire

// *** ccd_detect_window.sv ***
// Current-detect window and exceedance counter.
// Assumes conv_in pulses once per counted conversion and hit_in only with it.
`default_nettype none

module ccd_detect_window (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  ccd_cfg_if.det cfg,
  input wire logic conv_in,
  input wire logic hit_in,
  output logic detect_out
);
  ccd_pkg::ccd_det_e state, next_state;
  logic [11:0] win_cnt, next_win_cnt;
  logic [7:0] hit_cnt, next_hit_cnt;
  logic fired, next_fired;
  logic next_detect;

  always_comb begin
    next_state = state;
    next_win_cnt = win_cnt;
    next_hit_cnt = hit_cnt;
    next_fired = fired;
    next_detect = 1'b0;
    case (state)
      ccd_pkg::CCD_DET_IDLE: begin
        if (cfg.detect_mode_enable) begin
          next_state = ccd_pkg::CCD_DET_RUN;
        end
      end
      ccd_pkg::CCD_DET_RUN: begin
        // [RQ3] Count exceedances to target
        if (hit_in && !fired) begin
          next_hit_cnt = hit_cnt + 8'h01;
          if (next_hit_cnt == ccd_pkg::exceed_target(cfg.detect_exceed_count)) begin
            next_detect = 1'b1;
            next_fired = 1'b1;
          end
        end
        // [RQ4] Window length in conversions
        if (conv_in) begin
          if (win_cnt == ccd_pkg::window_len(cfg.detect_window_length) - 12'h001) begin
            next_win_cnt = 12'h000;
            next_hit_cnt = 8'h00;
            next_fired = 1'b0;
          end else begin
            next_win_cnt = win_cnt + 12'h001;
          end
        end
      end
      default: next_state = ccd_pkg::CCD_DET_IDLE;
    endcase
    // [RQ4] Mode runs only while enabled
    if (!cfg.detect_mode_enable) begin
      next_state = ccd_pkg::CCD_DET_IDLE;
      next_win_cnt = 12'h000;
      next_hit_cnt = 8'h00;
      next_fired = 1'b0;
      next_detect = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ccd_pkg::CCD_DET_IDLE;
      win_cnt <= 12'h000;
      hit_cnt <= 8'h00;
      fired <= 1'b0;
      detect_out <= 1'b0;
    end else begin
      state <= next_state;
      win_cnt <= next_win_cnt;
      hit_cnt <= next_hit_cnt;
      fired <= next_fired;
      detect_out <= next_detect;
    end
  end

  assign cfg.window_running = (state == ccd_pkg::CCD_DET_RUN);

  a_exceed_target: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ3]
    detect_out |-> $past(hit_in) && ($past(hit_cnt) + 8'h01 ==
      ccd_pkg::exceed_target($past(cfg.detect_exceed_count))))
    else $error("Detection without reaching exceedance count");
  a_detect_disabled: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ4]
    !cfg.detect_mode_enable |=> !detect_out && win_cnt == 12'h000)
    else $error("Detect activity while mode disabled");
  a_window_bound: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ4]
    win_cnt < ccd_pkg::window_len(cfg.detect_window_length))
    else $error("Window counter past selected length");
endmodule : ccd_detect_window

`default_nettype wire

// *** ccd_pkg.sv ***
// Shared constants, state types and helper functions for the chop and current-detect block.
// Assumes a single 100 MHz clock and the plain register port of the top module.
`default_nettype none

package ccd_pkg;
  // Register addresses
  localparam logic [3:0] ADDR_CONFIG = 4'h6;
  localparam logic [3:0] ADDR_THR_HIGH = 4'h7;
  localparam logic [3:0] ADDR_THR_LOW = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hF;
  // Reset values
  localparam logic [15:0] CONFIG_RESET = 16'h0600;
  localparam logic [15:0] THR_HIGH_RESET = 16'h0000;
  localparam logic [15:0] THR_LOW_RESET = 16'h0000;
  // Writable bits of the low threshold register; bits 7:4 read as zero
  localparam logic [15:0] THR_LOW_MASK = 16'hFF0F;
  // Field positions of the configuration register
  localparam int CHOP_DLY_MSB = 12;
  localparam int CHOP_DLY_LSB = 9;
  localparam int CHOP_EN_BIT = 8;
  localparam int ALLCH_BIT = 7;
  localparam int NUM_MSB = 6;
  localparam int NUM_LSB = 4;
  localparam int LEN_MSB = 3;
  localparam int LEN_LSB = 1;
  localparam int DET_EN_BIT = 0;
  // Field positions of the low threshold register
  localparam int THR_LOWER_MSB = 15;
  localparam int THR_LOWER_LSB = 8;
  // Status register bits
  localparam int ST_DETECT_BIT = 0;
  localparam int ST_SETTLE_BIT = 1;
  localparam int ST_WINDOW_BIT = 2;

  typedef enum logic [1:0] {
    CCD_CHOP_IDLE = 2'b00,
    CCD_CHOP_SETTLE = 2'b01,
    CCD_CHOP_MEASURE = 2'b10
  } ccd_chop_e;

  typedef enum logic [0:0] {
    CCD_DET_IDLE = 1'b0,
    CCD_DET_RUN = 1'b1
  } ccd_det_e;

  // Settling delay in modulator clock periods: 2 ** (code + 1)
  function automatic logic [16:0] chop_delay(input logic [3:0] code);
    return 17'h00002 << code;
  endfunction : chop_delay

  // Exceedances needed for a detection: 2 ** code
  function automatic logic [7:0] exceed_target(input logic [2:0] code);
    return 8'h01 << code;
  endfunction : exceed_target

  // Measurement window in conversion periods
  function automatic logic [11:0] window_len(input logic [2:0] code);
    logic [11:0] len;
    case (code)
      3'h0: len = 12'h080;
      3'h1: len = 12'h100;
      3'h2: len = 12'h200;
      3'h3: len = 12'h300;
      3'h4: len = 12'h500;
      3'h5: len = 12'h700;
      3'h6: len = 12'hA00;
      default: len = 12'hE00;
    endcase
    return len;
  endfunction : window_len

  // Magnitude of a two's complement conversion result
  function automatic logic [23:0] magnitude(input logic [23:0] d);
    return d[23] ? (~d + 24'h000001) : d;
  endfunction : magnitude
endpackage : ccd_pkg

`default_nettype wire

// *** ccd_tb_top.sv ***
// Self-checking bench for the chop and current-detect block.
// Assumes the source model supplies ticks and results; registers via the plain port.
`default_nettype none

module ccd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in;
  logic rst_b_in;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata_out;
  logic [3:0] ch_active;
  logic mod_tick;
  logic chop_start;
  logic conv_valid;
  logic [95:0] conv_data;
  logic measure_ok_out;
  logic detect_out;
  logic detect_flag_out;
  logic [15:0] rv;
  int n_fail;
  int n_checks;
  int cycles = 0;
  // Threshold is 0x000180: upper word 0x0001, lower byte 0x80
  localparam logic [23:0] HIT = 24'h000181;
  localparam logic [23:0] AT_THR = 24'h000180;
  localparam logic [23:0] LOW_ONLY = 24'h000150;
  localparam logic [23:0] NEG_HIT = 24'hFFFE7F;
  localparam logic [23:0] NONE = 24'h000000;
  int codes [4] = '{0, 1, 3, 7};

  ccd_top DUT (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata_out),
    .mod_tick_in(mod_tick),
    .chop_start_in(chop_start),
    .conv_valid_in(conv_valid),
    .ch_active_in(ch_active),
    .conv_data_in(conv_data),
    .measure_ok_out(measure_ok_out),
    .detect_out(detect_out),
    .detect_flag_out(detect_flag_out)
  );

  ccd_conv_model #(.TICK_DIV(3)) u_src (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .mod_tick_out(mod_tick),
    .chop_start_out(chop_start),
    .conv_valid_out(conv_valid),
    .conv_data_out(conv_data)
  );

  initial begin
    mclk_in = 1'b0;
  end

  always #5 mclk_in = ~mclk_in;

  task automatic test_done();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Roughly 800 cycles are needed; a hang is cut well beyond that
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : rd

  task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask : rchk

  // Ticks are counted in every cycle that the block spends settling
  task automatic chop_count(input int exp, input string what);
    int n;
    int k;
    n = 0;
    #1;
    // An enable write needs one more edge before settling shows
    for (k = 0; k < 4 && measure_ok_out === 1'b1; k++) begin
      @(posedge mclk_in);
      #1;
    end
    for (k = 0; k < 2000 && measure_ok_out !== 1'b1; k++) begin
      if (mod_tick === 1'b1) begin
        n++;
      end
      @(posedge mclk_in);
      #1;
    end
    chk(what, 16'(exp), 16'(n));
  endtask : chop_count

  task automatic arm(input logic [15:0] cfg);
    wr(ccd_pkg::ADDR_CONFIG, 16'h0000);
    wr(ccd_pkg::ADDR_CONFIG, cfg);
  endtask : arm

  task automatic conv(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c,
                      input logic [23:0] d, input logic exp);
    u_src.send({d, c, b, a});
    #1;
    chk("detect_out", {15'h0, exp}, {15'h0, detect_out});
  endtask : conv

  initial begin
    int i;
    int k;
    int code;
    rst_b_in = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ch_active = 4'hF;
    n_fail = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    #1;
    chk("measure_ok", 16'h0001, {15'h0, measure_ok_out});
    chk("detect_flag", 16'h0000, {15'h0, detect_flag_out});
    rchk(ccd_pkg::ADDR_CONFIG, 16'h0600, "config reset");
    rchk(ccd_pkg::ADDR_THR_HIGH, 16'h0000, "thr high reset");
    rchk(ccd_pkg::ADDR_THR_LOW, 16'h0000, "thr low reset");
    wr(ccd_pkg::ADDR_CONFIG, 16'hFFFF);
    rchk(ccd_pkg::ADDR_CONFIG, 16'hFFFF, "config rw");
    wr(ccd_pkg::ADDR_THR_HIGH, 16'hFFFF);
    rchk(ccd_pkg::ADDR_THR_HIGH, 16'hFFFF, "thr high rw");
    wr(ccd_pkg::ADDR_THR_LOW, 16'hFFFF);
    rchk(ccd_pkg::ADDR_THR_LOW, 16'hFF0F, "thr low rw");
    wr(4'h5, 16'h1234);
    rchk(4'h5, 16'h0000, "unmapped");
    wr(ccd_pkg::ADDR_THR_HIGH, 16'h0001);
    wr(ccd_pkg::ADDR_THR_LOW, 16'h80FF);
    rchk(ccd_pkg::ADDR_THR_LOW, 16'h800F, "thr low field");
    for (code = 0; code < 4; code++) begin
      arm(16'h0100 | 16'(code << 9));
      chop_count(2 << code, "chop ticks");
    end
    u_src.chop_mark();
    chop_count(16, "chop restart");
    // Disabling in mid-settle ends it one cycle later
    u_src.chop_mark();
    rchk(ccd_pkg::ADDR_STATUS, 16'h0002, "status settling");
    wr(ccd_pkg::ADDR_CONFIG, 16'h0600);
    @(posedge mclk_in);
    #1;
    chk("measure_ok off", 16'h0001, {15'h0, measure_ok_out});
    for (i = 0; i < 4; i++) begin
      arm(16'h0001 | 16'(codes[i] << 4));
      for (k = 1; k < (1 << codes[i]); k++) begin
        conv(HIT, NONE, NONE, NONE, 1'b0);
      end
      conv(HIT, NONE, NONE, NONE, 1'b1);
    end
    arm(16'h0001);
    conv(AT_THR, NONE, NONE, NONE, 1'b0);
    conv(LOW_ONLY, NONE, NONE, NONE, 1'b0);
    conv(NONE, NONE, NEG_HIT, NONE, 1'b1);
    rd(ccd_pkg::ADDR_STATUS, rv);
    chk("status flag", 16'h0001, rv & 16'h0001);
    wr(ccd_pkg::ADDR_STATUS, 16'h0001);
    rd(ccd_pkg::ADDR_STATUS, rv);
    chk("flag cleared", 16'h0000, rv & 16'h0001);
    chk("window running", 16'h0004, rv & 16'h0004);
    chk("detect_flag", 16'h0000, {15'h0, detect_flag_out});
    arm(16'h0011);
    for (k = 0; k < 127; k++) begin
      conv(AT_THR, NONE, NONE, NONE, 1'b0);
    end
    conv(HIT, NONE, NONE, NONE, 1'b0);
    conv(HIT, NONE, NONE, NONE, 1'b0);
    conv(HIT, NONE, NONE, NONE, 1'b1);
    arm(16'h0081);
    conv(HIT, HIT, NEG_HIT, AT_THR, 1'b0);
    conv(HIT, NEG_HIT, HIT, HIT, 1'b1);
    arm(16'h0081);
    ch_active <= 4'h7;
    conv(HIT, HIT, HIT, NONE, 1'b1);
    arm(16'h0001);
    ch_active <= 4'hF;
    conv(NONE, NONE, NONE, NEG_HIT, 1'b1);
    wr(ccd_pkg::ADDR_CONFIG, 16'h0000);
    conv(HIT, HIT, HIT, HIT, 1'b0);
    test_done();
  end
endmodule : ccd_tb_top

`default_nettype wire

// *** ccd_top.sv ***
// Chop and current-detect configuration block: registers, channel qualification and engines.
// Assumes a register master on the plain port and conversion results synchronous to mclk_in.
//
// Summary of operation
// [RQ1] With chop enabled, wait 2**(code+1) modulator periods before measuring; default 16.
// [RQ2] Qualification bit picks any channel (0) or all channels (1) to trigger.
// [RQ3] Detection needs 1, 2, 4 ... 128 exceedances; reset code selects one.
// [RQ4] Detect runs only while enabled; window lasts 128 to 3584 conversion periods.
// [RQ5] Upper sixteen threshold bits sit in a read-write register, reset zero.
// [RQ6] Lower threshold register follows the upper one, reset all zero.
// [RQ7] Bits 15:8 of the lower register complete a 24-bit threshold.
// [RQ8] Compare qualifying results in each window, count, signal detection at target.
`default_nettype none

module ccd_top (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic mod_tick_in,
  input wire logic chop_start_in,
  input wire logic conv_valid_in,
  input wire logic [3:0] ch_active_in,
  input wire logic [95:0] conv_data_in,
  output logic measure_ok_out,
  output logic detect_out,
  output logic detect_flag_out
);
  ccd_cfg_if cfg_bus ();

  logic [15:0] config_reg, next_config_reg;
  logic [15:0] thr_high, next_thr_high;
  logic [15:0] thr_low, next_thr_low;
  logic [15:0] next_rdata;
  logic detect_flag, next_detect_flag;
  logic [23:0] threshold;
  logic [3:0] exceed;
  logic qualify;
  logic counted_conv;
  logic detect_pulse;
  logic wr_config, wr_thr_high, wr_thr_low, wr_status;

  assign wr_config = reg_wr_in && (reg_addr_in == ccd_pkg::ADDR_CONFIG);
  assign wr_thr_high = reg_wr_in && (reg_addr_in == ccd_pkg::ADDR_THR_HIGH);
  assign wr_thr_low = reg_wr_in && (reg_addr_in == ccd_pkg::ADDR_THR_LOW);
  assign wr_status = reg_wr_in && (reg_addr_in == ccd_pkg::ADDR_STATUS);

  // Register file next values
  always_comb begin
    next_config_reg = config_reg;
    next_thr_high = thr_high;
    next_thr_low = thr_low;
    if (wr_config) begin
      next_config_reg = reg_wdata_in;
    end
    // [RQ5] Upper threshold full width
    if (wr_thr_high) begin
      next_thr_high = reg_wdata_in;
    end
    // [RQ6] Lower threshold register write
    if (wr_thr_low) begin
      next_thr_low = reg_wdata_in & ccd_pkg::THR_LOW_MASK;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      config_reg <= ccd_pkg::CONFIG_RESET;
      thr_high <= ccd_pkg::THR_HIGH_RESET;
      thr_low <= ccd_pkg::THR_LOW_RESET;
    end else begin
      config_reg <= next_config_reg;
      thr_high <= next_thr_high;
      thr_low <= next_thr_low;
    end
  end

  // Configuration fields out to the engines
  assign cfg_bus.chop_enable = config_reg[ccd_pkg::CHOP_EN_BIT];
  assign cfg_bus.chop_settle_delay = config_reg[ccd_pkg::CHOP_DLY_MSB:ccd_pkg::CHOP_DLY_LSB];
  assign cfg_bus.detect_mode_enable = config_reg[ccd_pkg::DET_EN_BIT];
  assign cfg_bus.detect_exceed_count = config_reg[ccd_pkg::NUM_MSB:ccd_pkg::NUM_LSB];
  assign cfg_bus.detect_window_length = config_reg[ccd_pkg::LEN_MSB:ccd_pkg::LEN_LSB];

  // [RQ7] Upper word plus lower byte
  assign threshold = {thr_high, thr_low[ccd_pkg::THR_LOWER_MSB:ccd_pkg::THR_LOWER_LSB]};

  // [RQ8] Per-channel magnitude compare
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      exceed[i] = conv_valid_in && ch_active_in[i] &&
                  (ccd_pkg::magnitude(conv_data_in[i*24 +: 24]) > threshold);
    end
  end

  // Conversions during chop settling are not trusted, so they neither count nor hit
  assign counted_conv = conv_valid_in && measure_ok_out;

  // [RQ2] Any or all channels
  always_comb begin
    if (config_reg[ccd_pkg::ALLCH_BIT]) begin
      qualify = counted_conv && (ch_active_in != 4'h0) && (exceed == ch_active_in);
    end else begin
      qualify = counted_conv && (exceed != 4'h0);
    end
  end

  ccd_chop_timer u_chop (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .cfg(cfg_bus.chop),
    .mod_tick_in(mod_tick_in),
    .chop_start_in(chop_start_in),
    .measure_ok_out(measure_ok_out)
  );

  ccd_detect_window u_det (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .cfg(cfg_bus.det),
    .conv_in(counted_conv),
    .hit_in(qualify),
    .detect_out(detect_pulse)
  );

  assign detect_out = detect_pulse;

  // [RQ8] Sticky detection, set wins over clear
  always_comb begin
    next_detect_flag = detect_flag;
    if (wr_status && reg_wdata_in[ccd_pkg::ST_DETECT_BIT]) begin
      next_detect_flag = 1'b0;
    end
    if (detect_pulse) begin
      next_detect_flag = 1'b1;
    end
  end

  // Read mux; unmapped addresses and idle cycles read zero
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        ccd_pkg::ADDR_CONFIG: next_rdata = config_reg;
        ccd_pkg::ADDR_THR_HIGH: next_rdata = thr_high;
        ccd_pkg::ADDR_THR_LOW: next_rdata = thr_low;
        ccd_pkg::ADDR_STATUS: begin
          next_rdata[ccd_pkg::ST_DETECT_BIT] = detect_flag;
          next_rdata[ccd_pkg::ST_SETTLE_BIT] = cfg_bus.chop_settling;
          next_rdata[ccd_pkg::ST_WINDOW_BIT] = cfg_bus.window_running;
        end
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      detect_flag <= 1'b0;
      reg_rdata_out <= 16'h0000;
    end else begin
      detect_flag <= next_detect_flag;
      reg_rdata_out <= next_rdata;
    end
  end

  assign detect_flag_out = detect_flag;

  a_thr_high_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ5]
    wr_thr_high |=> thr_high == $past(reg_wdata_in))
    else $error("Upper threshold did not read back");
  a_thr_low_rsvd: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ6]
    (reg_rd_in && reg_addr_in == ccd_pkg::ADDR_THR_LOW) |=> reg_rdata_out[7:4] == 4'h0)
    else $error("Reserved lower threshold bits not zero");
  a_thr_combine: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ7]
    wr_thr_low |=> threshold[7:0] == $past(reg_wdata_in[15:8]))
    else $error("Lower threshold byte not in threshold");
  a_any_channel: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ2]
    (!config_reg[ccd_pkg::ALLCH_BIT] && counted_conv && exceed != 4'h0) |-> qualify)
    else $error("Single channel exceedance not qualified");
  a_all_channels: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ2]
    (config_reg[ccd_pkg::ALLCH_BIT] && exceed != ch_active_in) |-> !qualify)
    else $error("Partial exceedance qualified in all mode");
  a_detect_sticky: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ8]
    detect_pulse |=> detect_flag_out)
    else $error("Detection flag not held");
  a_read_once: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [RQ5]
    !reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("Read data outside its cycle");
endmodule : ccd_top

`default_nettype wire
